// ==== rtl/hsb_pkg.sv ====
// Purpose: Shared constants for the hot-swap bus buffer control logic
// Assumes: 50 MHz system clock
// Notes:   Times are in ns; cycle counts derive from them
package hsb_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_TIME_NS  = 2000;
  localparam int IDLE_TIME_NS  = 60000;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int IDLE_CYCLES   = (IDLE_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;
  // Synchroniser depth, and its reset pattern: lines high, enable low
  localparam int SYNC_STAGES   = 2;
  localparam logic [4:0] SYNC_RST = 5'h1e;

  // ------------------------------------------------------------------
  // Connect state machine
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_INIT = 4'h2,
    ST_WAIT = 4'h4,
    ST_CONN = 4'h8
  } hsb_state_t;

endpackage : hsb_pkg

// ==== rtl/hsb_pair.sv ====
// Purpose: One connected line pair (data or clock) with low propagation
// Assumes: Inputs already synchronised; open-drain outputs, oe=drive low
// Notes:   Latches which side first went low to avoid self-holding
`timescale 1ns/100ps
module hsb_pair (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic connect,
  input  wire logic bp_in,
  input  wire logic cd_in,
  output logic      bp_oe,
  output logic      cd_oe,
  output logic      accel
);

  // Blanking counter must hold the synchroniser depth
  if (hsb_pkg::SYNC_STAGES < 1 || hsb_pkg::SYNC_STAGES > 3) begin : g_bad_hold
    $error("hsb_pair: synchroniser depth out of range");
  end

  localparam logic [1:0] HOLD_SET = 2'(hsb_pkg::SYNC_STAGES);

  logic       bp_drv_r;
  logic       bp_drv_nxt;
  logic       cd_drv_r;
  logic       cd_drv_nxt;
  logic       acc_r;
  logic       acc_nxt;
  logic [1:0] bp_hold_r;
  logic [1:0] bp_hold_nxt;
  logic [1:0] cd_hold_r;
  logic [1:0] cd_hold_nxt;
  logic       bp_low;
  logic       cd_low;

  // A wire we just let go still reads low through the synchronisers;
  // without blanking, the pair would echo its own release back and forth
  assign bp_low = !bp_in && (bp_hold_r == 2'h0);
  assign cd_low = !cd_in && (cd_hold_r == 2'h0);

  // ------------------------------------------------------------------
  // Pull-down direction
  // ------------------------------------------------------------------
  // A side we drive reads low; only a low we do not drive is external.
  always_comb begin
    bp_drv_nxt = 1'b0;
    cd_drv_nxt = 1'b0;
    acc_nxt    = 1'b0;
    if (connect) begin
      if (cd_drv_r) begin
        cd_drv_nxt = !bp_in;
      end else if (bp_drv_r) begin
        bp_drv_nxt = !cd_in;
      end else if (bp_low) begin
        cd_drv_nxt = 1'b1;
      end else if (cd_low) begin
        bp_drv_nxt = 1'b1;
      end
      // Release seen high: pull-down off, accelerator on for one cycle
      acc_nxt = (bp_drv_r || cd_drv_r) &&
                !(bp_drv_nxt || cd_drv_nxt);
    end
    bp_hold_nxt = (bp_hold_r == 2'h0) ? 2'h0 : bp_hold_r - 2'h1;
    cd_hold_nxt = (cd_hold_r == 2'h0) ? 2'h0 : cd_hold_r - 2'h1;
    if (bp_drv_r && !bp_drv_nxt) begin
      bp_hold_nxt = HOLD_SET;
    end
    if (cd_drv_r && !cd_drv_nxt) begin
      cd_hold_nxt = HOLD_SET;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bp_drv_r  <= 1'b0;
      cd_drv_r  <= 1'b0;
      acc_r     <= 1'b0;
      bp_hold_r <= 2'h0;
      cd_hold_r <= 2'h0;
    end else begin
      bp_drv_r  <= bp_drv_nxt;
      cd_drv_r  <= cd_drv_nxt;
      acc_r     <= acc_nxt;
      bp_hold_r <= bp_hold_nxt;
      cd_hold_r <= cd_hold_nxt;
    end
  end

  assign bp_oe = bp_drv_r;
  assign cd_oe = cd_drv_r;
  // Gated so a pulse launched just before enable fell never shows
  assign accel = acc_r && connect;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_pair_copy_low: assert property (
    @(posedge clock) disable iff (rst)
    connect && $past(connect) && !bp_in && bp_hold_r == 2'h0 &&
    !bp_drv_r && !cd_drv_r |=> cd_drv_r || !connect)
    else $error("card side not pulled after backplane low");
  a_pair_hold_low: assert property (
    @(posedge clock) disable iff (rst)
    cd_drv_r && !bp_in && connect |=> cd_drv_r || !connect)
    else $error("pair released while external low remains");
  a_pair_accel: assert property (
    @(posedge clock) disable iff (rst)
    accel |-> !bp_oe && !cd_oe)
    else $error("accelerator with pull-down on");

endmodule : hsb_pair

// ==== rtl/hsb_ctrl.sv ====
// Purpose: Connect control of a hot-swap two-wire bus buffer
// Assumes: All pins asynchronous to clock; rst models power-up
// Notes:   Open-drain pins: _in level, _oe high pulls the wire low
`timescale 1ns/100ps

// Behaviour
// - Enable low isolates both sides, kills accelerators and pull-ups.
// - The ready flag is pulled low when disconnected, released connected.
// - During power-up only the ready flag is driven (low) until init releases the part.
// - Power-up with enable high or an enable rise starts initialization.
// - The stop and idle detector arms only after initialization ends.
// - Connect after all four lines idle high long enough or on a STOP.
// - Backplane pull-ups stay on from init until enable low or reset.
// - While connected a low on one pin of a pair drives the other low.
// - Both pins stay low until the external driver on the side that went low first lets go.
// - On a release the pull-down turns off and accelerators fire.
// - After enable rises, wait for both sides to finish traffic.
// - Ready goes high only with enable high and start-up complete.
module hsb_ctrl #(
  parameter int INIT_CYCLES = hsb_pkg::INIT_CYCLES,
  parameter int IDLE_CYCLES = hsb_pkg::IDLE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic backplane_data_line_in,
  output logic      backplane_data_line_oe,
  input  wire logic backplane_clock_line_in,
  output logic      backplane_clock_line_oe,
  input  wire logic card_data_line_in,
  output logic      card_data_line_oe,
  input  wire logic card_clock_line_in,
  output logic      card_clock_line_oe,
  output logic      ready_oe,
  output logic      pullup_on,
  output logic      accel_data,
  output logic      accel_clock
);

  // Counts must fit the shared counter
  if (INIT_CYCLES < 1 || IDLE_CYCLES < 1 ||
      INIT_CYCLES >= (1 << hsb_pkg::CNT_W) ||
      IDLE_CYCLES >= (1 << hsb_pkg::CNT_W)) begin : g_bad_counts
    $error("hsb_ctrl: cycle counts out of range");
  end

  localparam logic [hsb_pkg::CNT_W-1:0] INIT_LAST =
    (hsb_pkg::CNT_W)'(INIT_CYCLES - 1);
  localparam logic [hsb_pkg::CNT_W-1:0] IDLE_LAST =
    (hsb_pkg::CNT_W)'(IDLE_CYCLES - 1);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // Bit order: 0 enable, 1 bp data, 2 bp clock, 3 card data, 4 card clock
  logic [4:0] pin_raw;
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic [4:0] sync_nxt;

  assign pin_raw = {card_clock_line_in, card_data_line_in,
                    backplane_clock_line_in, backplane_data_line_in, enable};

  // Lines idle high after reset so no false STOP is seen
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= hsb_pkg::SYNC_RST;
      sync_r <= hsb_pkg::SYNC_RST;
    end else begin
      meta_r <= pin_raw;
      sync_r <= sync_nxt;
    end
  end
  always_comb begin
    sync_nxt = meta_r;
  end

  logic en_s;
  logic bpd_s;
  logic bpc_s;
  logic cdd_s;
  logic cdc_s;
  assign en_s  = sync_r[0];
  assign bpd_s = sync_r[1];
  assign bpc_s = sync_r[2];
  assign cdd_s = sync_r[3];
  assign cdc_s = sync_r[4];

  // ------------------------------------------------------------------
  // Connect state machine
  // ------------------------------------------------------------------
  hsb_pkg::hsb_state_t         st_r;
  hsb_pkg::hsb_state_t         st_nxt;
  logic [hsb_pkg::CNT_W-1:0]   cnt_r;
  logic [hsb_pkg::CNT_W-1:0]   cnt_nxt;
  logic                        bpd_prev_r;
  logic                        bpd_prev_nxt;
  logic                        all_high;
  logic                        stop_seen;

  assign all_high  = bpd_s && bpc_s && cdd_s && cdc_s;
  // STOP: backplane data rises while backplane clock is high
  assign stop_seen = bpd_s && !bpd_prev_r && bpc_s;

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    bpd_prev_nxt = bpd_s;
    case (st_r)
      hsb_pkg::ST_OFF: begin
        cnt_nxt = '0;
        if (en_s) begin
          st_nxt = hsb_pkg::ST_INIT;
        end
      end
      hsb_pkg::ST_INIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == INIT_LAST) begin
          st_nxt  = hsb_pkg::ST_WAIT;
          cnt_nxt = '0;
        end
      end
      hsb_pkg::ST_WAIT: begin
        // Any low on any line restarts the idle count
        cnt_nxt = all_high ? cnt_r + 1'b1 : '0;
        if (all_high && (stop_seen || cnt_r == IDLE_LAST)) begin
          st_nxt = hsb_pkg::ST_CONN;
        end
      end
      hsb_pkg::ST_CONN: begin
        cnt_nxt = '0;
      end
      default: begin
        st_nxt  = hsb_pkg::ST_OFF;
        cnt_nxt = '0;
      end
    endcase
    if (!en_s) begin
      st_nxt  = hsb_pkg::ST_OFF;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r       <= hsb_pkg::ST_OFF;
      cnt_r      <= '0;
      bpd_prev_r <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      bpd_prev_r <= bpd_prev_nxt;
    end
  end

  logic connected;
  assign connected = (st_r == hsb_pkg::ST_CONN) && en_s;

  // ------------------------------------------------------------------
  // Line pairs
  // ------------------------------------------------------------------
  hsb_pair u_data (
    .clock   (clock),
    .rst     (rst),
    .connect (connected),
    .bp_in   (bpd_s),
    .cd_in   (cdd_s),
    .bp_oe   (backplane_data_line_oe),
    .cd_oe   (card_data_line_oe),
    .accel   (accel_data)
  );

  hsb_pair u_clock (
    .clock   (clock),
    .rst     (rst),
    .connect (connected),
    .bp_in   (bpc_s),
    .cd_in   (cdc_s),
    .bp_oe   (backplane_clock_line_oe),
    .cd_oe   (card_clock_line_oe),
    .accel   (accel_clock)
  );

  // ------------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------------
  assign ready_oe  = !connected;
  assign pullup_on = (st_r != hsb_pkg::ST_OFF) && en_s;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_init_done;
    st_r == hsb_pkg::ST_INIT ##1 st_r == hsb_pkg::ST_WAIT;
  endsequence

  sequence s_wait_conn;
    st_r == hsb_pkg::ST_WAIT ##1 st_r == hsb_pkg::ST_CONN;
  endsequence

  a_en_low_iso: assert property (
    @(posedge clock) disable iff (rst)
    !en_s |-> ready_oe && !accel_data && !accel_clock && !pullup_on)
    else $error("part active with enable low");
  a_en_low_lines: assert property (
    @(posedge clock) disable iff (rst)
    !en_s |=> !backplane_data_line_oe && !card_data_line_oe &&
              !backplane_clock_line_oe && !card_clock_line_oe)
    else $error("lines still driven with enable low");
  a_ready_conn: assert property (
    @(posedge clock) disable iff (rst)
    !ready_oe |-> st_r == hsb_pkg::ST_CONN && en_s)
    else $error("ready released while disconnected");
  a_reset_quiet: assert property (
    @(posedge clock)
    rst |=> ready_oe && !backplane_data_line_oe && !card_data_line_oe)
    else $error("lines driven after reset");
  a_init_start: assert property (
    @(posedge clock) disable iff (rst)
    st_r == hsb_pkg::ST_OFF && en_s |=> st_r == hsb_pkg::ST_INIT)
    else $error("init not started on enable");
  a_init_len: assert property (
    @(posedge clock) disable iff (rst)
    s_init_done |-> $past(cnt_r) == INIT_LAST)
    else $error("init length wrong");
  a_conn_cause: assert property (
    @(posedge clock) disable iff (rst)
    $rose(st_r == hsb_pkg::ST_CONN) |-> $past(st_r) == hsb_pkg::ST_WAIT)
    else $error("connected without passing the wait state");
  a_conn_idle: assert property (
    @(posedge clock) disable iff (rst)
    s_wait_conn |-> $past(all_high) &&
      (($past(bpd_s) && !$past(bpd_s, 2) && $past(bpc_s)) ||
       $past(cnt_r) == IDLE_LAST))
    else $error("connect without idle or stop");
  a_pullup_hold: assert property (
    @(posedge clock) disable iff (rst)
    $fell(pullup_on) |-> !en_s)
    else $error("pull-up dropped while enabled");

endmodule : hsb_ctrl

// ==== sim/hsb_bus_agent.sv ====
// Purpose: Masters and slaves on the backplane and card segments
// Assumes: Wires are open-drain with pull-ups, resolved by the bench
// Notes:   Link clock steps are half of a 160 ns period
`timescale 1ns/100ps
module hsb_bus_agent (
  input  wire logic clock,
  output logic      bp_data_pull,
  output logic      bp_clock_pull,
  output logic      cd_data_pull,
  output logic      cd_clock_pull
);
  // One buffer between the two segments, light load
  initial begin
    bp_data_pull  = 1'b0;
    bp_clock_pull = 1'b0;
    cd_data_pull  = 1'b0;
    cd_clock_pull = 1'b0;
  end

  task automatic half;
    repeat (4) @(posedge clock);
    #2;
  endtask : half

  // Clock stands high outside the frame; data rises while it is high
  task automatic send_stop;
    bp_data_pull = 1'b1;
    half();
    bp_clock_pull = 1'b1;
    half();
    bp_clock_pull = 1'b0;
    half();
    bp_data_pull = 1'b0;
    half();
  endtask : send_stop
endmodule : hsb_bus_agent

// ==== sim/hot_swap_i2c_connect_control_tb_top.sv ====
// Purpose: Self-checking bench for the hot-swap connect control
// Assumes: Short init and idle counts so the run stays brief
// Notes:   Wire levels are worked out from every party's pull-down
`timescale 1ns/100ps
module hot_swap_i2c_connect_control_tb_top;
  logic clock, rst, enable;
  logic bp_d_oe, bp_c_oe, cd_d_oe, cd_c_oe;
  logic ready_oe, pullup_on, accel_data, accel_clock;
  logic bp_d_pull, bp_c_pull, cd_d_pull, cd_c_pull;
  wire  bp_d = ~(bp_d_oe | bp_d_pull);
  wire  bp_c = ~(bp_c_oe | bp_c_pull);
  wire  cd_d = ~(cd_d_oe | cd_d_pull);
  wire  cd_c = ~(cd_c_oe | cd_c_pull);
  int   n_mismatch = 0;
  int   checks_done = 0;

  hsb_ctrl #(.INIT_CYCLES(4), .IDLE_CYCLES(20)) hsb_ctrl_i (
    .clock(clock), .rst(rst), .enable(enable),
    .backplane_data_line_in(bp_d), .backplane_data_line_oe(bp_d_oe),
    .backplane_clock_line_in(bp_c), .backplane_clock_line_oe(bp_c_oe),
    .card_data_line_in(cd_d), .card_data_line_oe(cd_d_oe),
    .card_clock_line_in(cd_c), .card_clock_line_oe(cd_c_oe),
    .ready_oe(ready_oe), .pullup_on(pullup_on),
    .accel_data(accel_data), .accel_clock(accel_clock));

  hsb_bus_agent hsb_bus_agent_i (
    .clock(clock), .bp_data_pull(bp_d_pull), .bp_clock_pull(bp_c_pull),
    .cd_data_pull(cd_d_pull), .cd_clock_pull(cd_c_pull));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : cyc

  function automatic logic pick(input int sel);
    case (sel)
      0: return ready_oe;
      1: return bp_d_oe;
      2: return cd_c_oe;
      4: return accel_data;
      5: return accel_clock;
      6: return bp_c_oe;
      default: return cd_d;
    endcase
  endfunction : pick

  // A wait that runs out is a mismatch and ends the run
  task automatic wait_sig(input string what, input int sel, input logic want,
                          input int lim);
    for (int i = 0; i < lim && pick(sel) !== want; i++) cyc(1);
    chk(what, want, pick(sel));
    if (pick(sel) !== want) print_verdict();
  endtask : wait_sig

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk("ready_oe", 1'b1, ready_oe);
    chk("line oe", 1'b0, bp_d_oe | bp_c_oe | cd_d_oe | cd_c_oe);
    chk("pullup_on", 1'b0, pullup_on);
  endtask : t_reset

  task automatic t_stop_connect;
    hsb_bus_agent_i.cd_data_pull = 1'b1;
    enable = 1'b1;
    cyc(12);
    chk("pullup_on", 1'b1, pullup_on);
    cyc(30);
    chk("ready_oe busy card", 1'b1, ready_oe);
    chk("bp data oe early", 1'b0, bp_d_oe);
    hsb_bus_agent_i.cd_data_pull = 1'b0;
    hsb_bus_agent_i.send_stop();
    wait_sig("ready_oe after stop", 0, 1'b0, 8);
  endtask : t_stop_connect

  task automatic t_pass_data;
    hsb_bus_agent_i.cd_data_pull = 1'b1;
    wait_sig("bp data oe", 1, 1'b1, 8);
    hsb_bus_agent_i.bp_data_pull = 1'b1;
    cyc(4);
    hsb_bus_agent_i.cd_data_pull = 1'b0;
    cyc(8);
    chk("card data held", 1'b0, cd_d);
    hsb_bus_agent_i.bp_data_pull = 1'b0;
    // Accelerator stands one cycle, so it is polled every cycle
    wait_sig("accel_data", 4, 1'b1, 10);
    wait_sig("card data free", 3, 1'b1, 2);
  endtask : t_pass_data

  task automatic t_pass_clock;
    hsb_bus_agent_i.bp_clock_pull = 1'b1;
    wait_sig("card clock oe", 2, 1'b1, 8);
    hsb_bus_agent_i.bp_clock_pull = 1'b0;
    wait_sig("accel_clock", 5, 1'b1, 8);
    wait_sig("card clock free", 2, 1'b0, 2);
    hsb_bus_agent_i.cd_clock_pull = 1'b1;
    wait_sig("bp clock oe", 6, 1'b1, 8);
    hsb_bus_agent_i.cd_clock_pull = 1'b0;
    wait_sig("bp clock free", 6, 1'b0, 8);
  endtask : t_pass_clock

  task automatic t_disable_idle;
    enable = 1'b0;
    wait_sig("ready_oe off", 0, 1'b1, 6);
    chk("pullup_on off", 1'b0, pullup_on);
    hsb_bus_agent_i.cd_data_pull = 1'b1;
    cyc(6);
    chk("bp data isolated", 1'b0, bp_d_oe);
    hsb_bus_agent_i.cd_data_pull = 1'b0;
    enable = 1'b1;
    cyc(12);
    chk("ready_oe before idle", 1'b1, ready_oe);
    wait_sig("ready_oe idle", 0, 1'b0, 30);
  endtask : t_disable_idle

  initial begin
    rst = 1'b1;
    enable = 1'b0;
    repeat (5) @(posedge clock);
    #2;
    rst = 1'b0;
    cyc(2);
    t_reset();
    t_stop_connect();
    t_pass_data();
    t_pass_clock();
    t_disable_idle();
    print_verdict();
  end
endmodule : hot_swap_i2c_connect_control_tb_top
